// ### hdl/hcer_pkg.sv
// Package: register map, field layout, event codes and carriers for the reporter
package hcer_pkg;

	localparam logic [7:0] REG_CTRL   = 8'h00;
	localparam logic [7:0] REG_CMD    = 8'h04;
	localparam logic [7:0] REG_STATUS = 8'h08;
	localparam logic [7:0] REG_IMASK  = 8'h0c;
	localparam logic [7:0] REG_STATE  = 8'h10;

	// Control register field positions
	localparam int CTRL_IDLE_MASK  = 0;
	localparam int CTRL_OOF_MASK   = 1;
	localparam int CTRL_UP_MASK    = 2;
	localparam int CTRL_DOWN_MASK  = 3;
	localparam int CTRL_FILT_MASK  = 4;
	localparam int CTRL_BUF_MASK   = 5;
	localparam int CTRL_SIG_MODE   = 6;
	localparam int CTRL_WIDTH      = 7;
	localparam int CMD_REACTIVATE  = 0;

	localparam logic [6:0] CTRL_RESET  = 7'h00;
	localparam logic [7:0] IMASK_RESET = 8'h00;

	// Octet patterns, first received bit in bit 0
	localparam logic [7:0] IDLE_OCTET  = 8'h7e;
	localparam logic [7:0] ABORT_OCTET = 8'hfe;

	localparam int GOOD_RUN        = 256;
	localparam int REPEAT_MIN_LEN  = 3;
	localparam int REPEAT_MAX_LEN  = 5;
	localparam int ABORT_RUN_BITS  = 16;

	localparam logic [1:0] RESP_OKAY   = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

	// Event indices: also the bit positions of status and mask registers
	typedef enum logic [2:0] {
		EV_ABORT_ONSET, EV_IDLE_ONSET, EV_FRAME_REGAINED, EV_MON_UP,
		EV_MON_DOWN, EV_REPEAT_FILTERED, EV_OWN_UNDERFLOW, EV_FIFO_UNDERRUN
	} hcer_event_t;

	localparam int NUM_EVENTS = 8;

	// Descriptor handed to the interrupt queue writer
	typedef struct packed {
		logic        is_error;
		logic        dir;
		hcer_event_t code;
	} hcer_desc_t;

	// Per-message error flags from the receive bit-level processor
	typedef struct packed {
		logic short_msg;
		logic align_err;
		logic check_err;
		logic octet_count_err;
	} hcer_rx_err_t;

endpackage

// ### hdl/hcer_top.sv
// Event and error reporter for one HDLC channel, AXI4-Lite register slave
//
// Operation
// - Fill-to-abort change queues abort-onset event
// - Abort-to-fill change queues idle-onset event
// - Out-of-frame to in-frame queues recovery event
// - Signalling errors raise monitor counter, queue event
// - 256 clean messages lower monitor counter once
// - Each monitor decrement queues a down event
// - Clean repeat of 3-5 octet message detected
// - Filtered repeat dropped, filter event queued
// - Non-final buffer then host-owned next: underflow
// - Ownership underflow queues error, direction one
// - Underflow aborts channel, sends ones pattern
// - Ownership underflow: no status write, polling stops
// - FIFO empty while sending and owning: under-run
// - Under-run queues error, aborts, stops polling
// - Under-run leaves buffer status unwritten
`timescale 1ns/10ps
module hcer_top #(
	parameter int MON_WIDTH = 8
) (
	input  wire logic                  aclk,
	input  wire logic                  aresetn,
	input  wire logic [7:0]            s_axi_awaddr,
	input  wire logic                  s_axi_awvalid,
	output logic                       s_axi_awready,
	input  wire logic [31:0]           s_axi_wdata,
	input  wire logic [3:0]            s_axi_wstrb,
	input  wire logic                  s_axi_wvalid,
	output logic                       s_axi_wready,
	output logic [1:0]                 s_axi_bresp,
	output logic                       s_axi_bvalid,
	input  wire logic                  s_axi_bready,
	input  wire logic [7:0]            s_axi_araddr,
	input  wire logic                  s_axi_arvalid,
	output logic                       s_axi_arready,
	output logic [31:0]                s_axi_rdata,
	output logic [1:0]                 s_axi_rresp,
	output logic                       s_axi_rvalid,
	input  wire logic                  s_axi_rready,
	input  wire logic                  in_frame_pin,
	input  wire logic                  rx_oct_valid,
	input  wire logic [7:0]            rx_oct,
	input  wire logic                  rx_in_msg,
	input  wire logic                  rx_msg_end,
	input  wire hcer_pkg::hcer_rx_err_t rx_msg_err,
	output logic                       rx_msg_drop,
	input  wire logic                  tx_bit_tick,
	input  wire logic                  tx_data_bit,
	input  wire logic                  tx_fifo_empty,
	input  wire logic                  tx_buf_owned,
	input  wire logic                  tx_next_req,
	input  wire logic                  tx_cur_eom,
	input  wire logic                  tx_next_owned,
	output logic                       tx_line_bit,
	output logic                       tx_aborted,
	output logic                       tx_poll_en,
	output logic                       tx_status_wr_en,
	output logic                       evt_valid,
	input  wire logic                  evt_ready,
	output hcer_pkg::hcer_desc_t       evt_desc,
	output logic                       irq
);

	localparam int NE = hcer_pkg::NUM_EVENTS;

	// Refused at elaboration: the state word has room for 16 monitor bits
	if (MON_WIDTH < 2 || MON_WIDTH > 16) begin : g_bad_width
		$error("MON_WIDTH must lie between 2 and 16");
	end

	////////////////////////////////////////////////////////////////////////
	// Register bus

	logic [6:0]         ctrl_q;
	logic [NE-1:0]      status_q;
	logic [NE-1:0]      imask_q;
	logic               aw_held_q;
	logic               w_held_q;
	logic [7:0]         awaddr_q;
	logic [31:0]        wdata_q;
	logic [3:0]         wstrb_q;
	logic               wr_fire;
	logic               reactivate;
	logic [NE-1:0]      status_clr;
	logic [NE-1:0]      ev;
	logic [31:0]        rd_word;
	logic               rd_hit;
	logic               in_frame_s1_q;
	logic               in_frame_s2_q;
	logic               in_frame_q;
	logic [MON_WIDTH-1:0] mon_q;
	logic               aborted_q;
	logic               idle_seen_q;
	logic               abort_seen_q;

	assign s_axi_awready = !aw_held_q && !s_axi_bvalid;
	assign s_axi_wready  = !w_held_q && !s_axi_bvalid;
	assign wr_fire       = aw_held_q && w_held_q && !s_axi_bvalid;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_q <= 1'b0;
			w_held_q  <= 1'b0;
			awaddr_q  <= 8'h00;
			wdata_q   <= 32'h0000_0000;
			wstrb_q   <= 4'h0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held_q <= 1'b1;
				awaddr_q  <= s_axi_awaddr;
			end else if (wr_fire) begin
				aw_held_q <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held_q <= 1'b1;
				wdata_q  <= s_axi_wdata;
				wstrb_q  <= s_axi_wstrb;
			end else if (wr_fire) begin
				w_held_q <= 1'b0;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= hcer_pkg::RESP_OKAY;
		end else if (wr_fire) begin
			s_axi_bvalid <= 1'b1;
			if (awaddr_q == hcer_pkg::REG_CTRL ||
			    awaddr_q == hcer_pkg::REG_CMD ||
			    awaddr_q == hcer_pkg::REG_STATUS ||
			    awaddr_q == hcer_pkg::REG_IMASK ||
			    awaddr_q == hcer_pkg::REG_STATE)
				s_axi_bresp <= hcer_pkg::RESP_OKAY;
			else
				s_axi_bresp <= hcer_pkg::RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_q  <= hcer_pkg::CTRL_RESET;
			imask_q <= hcer_pkg::IMASK_RESET;
		end else if (wr_fire && wstrb_q[0]) begin
			if (awaddr_q == hcer_pkg::REG_CTRL)
				ctrl_q <= wdata_q[6:0];
			else if (awaddr_q == hcer_pkg::REG_IMASK)
				imask_q <= wdata_q[7:0];
		end
	end

	assign reactivate = wr_fire && wstrb_q[0] &&
		awaddr_q == hcer_pkg::REG_CMD &&
		wdata_q[hcer_pkg::CMD_REACTIVATE];
	assign status_clr = (wr_fire && wstrb_q[0] &&
		awaddr_q == hcer_pkg::REG_STATUS) ? wdata_q[7:0] : 8'h00;

	// A new event wins over a clear in the same cycle
	always_ff @(posedge aclk) begin
		if (!aresetn)
			status_q <= 8'h00;
		else
			status_q <= (status_q & ~status_clr) | ev;
	end

	assign irq = |(status_q & imask_q);

	always_comb begin
		rd_word = 32'h0000_0000;
		rd_hit  = 1'b1;
		if (s_axi_araddr == hcer_pkg::REG_CTRL)
			rd_word[6:0] = ctrl_q;
		else if (s_axi_araddr == hcer_pkg::REG_CMD)
			rd_word = 32'h0000_0000;
		else if (s_axi_araddr == hcer_pkg::REG_STATUS)
			rd_word[7:0] = status_q;
		else if (s_axi_araddr == hcer_pkg::REG_IMASK)
			rd_word[7:0] = imask_q;
		else if (s_axi_araddr == hcer_pkg::REG_STATE)
			rd_word = {12'h000, 16'(mon_q), in_frame_q,
				abort_seen_q, idle_seen_q, aborted_q};
		else
			rd_hit = 1'b0;
	end

	assign s_axi_arready = !s_axi_rvalid;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0000_0000;
			s_axi_rresp  <= hcer_pkg::RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata  <= rd_word;
			s_axi_rresp  <= rd_hit ? hcer_pkg::RESP_OKAY
				: hcer_pkg::RESP_SLVERR;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Receive line state: fill/abort changes and framing

	logic ev_abort_on;
	logic ev_idle_on;
	logic ev_frame;

	// Only a change between the two fill patterns reports; startup is silent
	assign ev_abort_on = rx_oct_valid && !rx_in_msg && idle_seen_q &&
		rx_oct == hcer_pkg::ABORT_OCTET;
	assign ev_idle_on  = rx_oct_valid && !rx_in_msg && abort_seen_q &&
		rx_oct == hcer_pkg::IDLE_OCTET;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			idle_seen_q  <= 1'b0;
			abort_seen_q <= 1'b0;
		end else if (rx_oct_valid && !rx_in_msg) begin
			idle_seen_q  <= rx_oct == hcer_pkg::IDLE_OCTET;
			abort_seen_q <= rx_oct == hcer_pkg::ABORT_OCTET;
		end else if (rx_oct_valid) begin
			idle_seen_q  <= 1'b0;
			abort_seen_q <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			in_frame_s1_q <= 1'b0;
			in_frame_s2_q <= 1'b0;
			in_frame_q    <= 1'b0;
		end else begin
			in_frame_s1_q <= in_frame_pin;
			in_frame_s2_q <= in_frame_s1_q;
			in_frame_q    <= in_frame_s2_q;
		end
	end

	assign ev_frame = in_frame_s2_q && !in_frame_q;

	////////////////////////////////////////////////////////////////////////
	// Signalling-link error monitor and repeat filter

	logic       sig_mode;
	logic       msg_bad;
	logic       msg_good;
	logic [7:0] good_run_q;
	logic       ev_mon_up;
	logic       ev_mon_down;
	logic [7:0] cur_q [hcer_pkg::REPEAT_MAX_LEN];
	logic [7:0] prev_q [hcer_pkg::REPEAT_MAX_LEN];
	logic [2:0] cur_len_q;
	logic [2:0] prev_len_q;
	logic       prev_ok_q;
	logic       same;
	logic       ev_filter;

	assign sig_mode = ctrl_q[hcer_pkg::CTRL_SIG_MODE];
	assign msg_bad  = sig_mode && rx_msg_end && (|rx_msg_err);
	assign msg_good = sig_mode && rx_msg_end && !(|rx_msg_err);
	assign ev_mon_up = msg_bad && !(&mon_q);
	assign ev_mon_down = msg_good &&
		good_run_q == 8'(hcer_pkg::GOOD_RUN - 1) &&
		(|mon_q);

	always_ff @(posedge aclk) begin
		if (!aresetn)
			mon_q <= '0;
		else if (ev_mon_up)
			mon_q <= mon_q + 1'b1;
		else if (ev_mon_down)
			mon_q <= mon_q - 1'b1;
	end

	// Run of clean messages; any errored one restarts it
	always_ff @(posedge aclk) begin
		if (!aresetn || !sig_mode)
			good_run_q <= 8'h00;
		else if (msg_bad)
			good_run_q <= 8'h00;
		else if (msg_good)
			good_run_q <= good_run_q + 8'h01;
	end

	// Only the first five octets are kept; longer messages never match
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cur_len_q <= 3'h0;
		end else if (rx_msg_end) begin
			cur_len_q <= 3'h0;
		end else if (rx_oct_valid && rx_in_msg) begin
			if (cur_len_q < 3'(hcer_pkg::REPEAT_MAX_LEN))
				cur_q[cur_len_q] <= rx_oct;
			if (cur_len_q <= 3'(hcer_pkg::REPEAT_MAX_LEN))
				cur_len_q <= cur_len_q + 3'h1;
		end
	end

	always_comb begin
		same = prev_ok_q && cur_len_q == prev_len_q &&
			cur_len_q >= 3'(hcer_pkg::REPEAT_MIN_LEN) &&
			cur_len_q <= 3'(hcer_pkg::REPEAT_MAX_LEN);
		for (int i = 0; i < hcer_pkg::REPEAT_MAX_LEN; i++)
			if (3'(i) < cur_len_q && cur_q[i] != prev_q[i])
				same = 1'b0;
	end

	assign ev_filter = msg_good && same;

	always_ff @(posedge aclk) begin
		if (!aresetn || !sig_mode) begin
			prev_ok_q  <= 1'b0;
			prev_len_q <= 3'h0;
		end else if (msg_good) begin
			prev_ok_q  <= 1'b1;
			prev_len_q <= cur_len_q;
			prev_q     <= cur_q;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn)
			rx_msg_drop <= 1'b0;
		else
			rx_msg_drop <= ev_filter;
	end

	////////////////////////////////////////////////////////////////////////
	// Transmit underflow handling

	logic ev_own;
	logic ev_fifo;

	assign ev_own  = !aborted_q && tx_next_req && !tx_cur_eom &&
		!tx_next_owned;
	assign ev_fifo = !aborted_q && tx_bit_tick && tx_fifo_empty &&
		tx_buf_owned;

	// Stays aborted until software reactivates the channel
	always_ff @(posedge aclk) begin
		if (!aresetn)
			aborted_q <= 1'b0;
		else if (ev_own || ev_fifo)
			aborted_q <= 1'b1;
		else if (reactivate)
			aborted_q <= 1'b0;
	end

	// Abort pattern is an unbroken run of ones for as long as the channel stays aborted
	always_ff @(posedge aclk) begin
		if (!aresetn)
			tx_line_bit <= 1'b1;
		else if (tx_bit_tick)
			tx_line_bit <= aborted_q || ev_own || ev_fifo ||
				tx_data_bit;
	end

	assign tx_aborted      = aborted_q;
	assign tx_poll_en      = !aborted_q;
	assign tx_status_wr_en = !aborted_q;

	////////////////////////////////////////////////////////////////////////
	// Event queue: pending bits issued lowest index first

	logic [NE-1:0] qmask;
	logic [NE-1:0] pend_q;
	logic [NE-1:0] pick;
	logic [2:0]    pick_idx;
	logic          pick_err;

	assign ev = {ev_fifo, ev_own, ev_filter, ev_mon_down, ev_mon_up,
		ev_frame, ev_idle_on, ev_abort_on};
	assign qmask = {
		{2{ctrl_q[hcer_pkg::CTRL_BUF_MASK]}},
		ctrl_q[hcer_pkg::CTRL_FILT_MASK],
		ctrl_q[hcer_pkg::CTRL_DOWN_MASK],
		ctrl_q[hcer_pkg::CTRL_UP_MASK],
		ctrl_q[hcer_pkg::CTRL_OOF_MASK],
		{2{ctrl_q[hcer_pkg::CTRL_IDLE_MASK]}}};

	always_comb begin
		pick     = '0;
		pick_idx = 3'h0;
		for (int i = NE - 1; i >= 0; i--)
			if (pend_q[i]) begin
				pick     = '0;
				pick[i]  = 1'b1;
				pick_idx = 3'(i);
			end
	end

	// New events of the same kind merge into the pending one
	always_ff @(posedge aclk) begin
		if (!aresetn)
			pend_q <= '0;
		else
			pend_q <= (pend_q & ~((evt_valid && evt_ready) ? pick : '0))
				| (ev & ~qmask);
	end

	assign evt_valid         = |pend_q;
	assign pick_err = pick_idx >= 3'(hcer_pkg::EV_OWN_UNDERFLOW);
	assign evt_desc = '{is_error: pick_err, dir: pick_err,
		code: hcer_pkg::hcer_event_t'(pick_idx)};

	////////////////////////////////////////////////////////////////////////
	// Checks

	AST_ABORT_EVT: assert property (@(posedge aclk) disable iff (!aresetn)
		ev_abort_on && !ctrl_q[0] |=> pend_q[0])
		else $error("abort onset not queued");
	AST_IDLE_EVT: assert property (@(posedge aclk) disable iff (!aresetn)
		ev_idle_on && !ctrl_q[0] |=> pend_q[1])
		else $error("idle onset not queued");
	AST_FRAME_EVT: assert property (@(posedge aclk) disable iff (!aresetn)
		$rose(in_frame_s2_q) && !ctrl_q[hcer_pkg::CTRL_OOF_MASK] |=>
		pend_q[hcer_pkg::EV_FRAME_REGAINED])
		else $error("frame recovery missed");
	AST_MON_UP: assert property (@(posedge aclk) disable iff (!aresetn)
		msg_bad && !(&mon_q) |=> mon_q == $past(mon_q) + 1'b1)
		else $error("monitor did not count up");
	AST_MON_DOWN: assert property (@(posedge aclk) disable iff (!aresetn)
		ev_mon_down |=> mon_q == $past(mon_q) - 1'b1 && good_run_q == 8'h00)
		else $error("monitor did not count down");
	AST_FILTER_DROP: assert property (@(posedge aclk) disable iff (!aresetn)
		ev_filter |=> rx_msg_drop ##1 !rx_msg_drop || ev_filter)
		else $error("repeat not dropped");
	AST_OWN_ABORT: assert property (@(posedge aclk) disable iff (!aresetn)
		ev_own |=> aborted_q && !tx_poll_en && !tx_status_wr_en)
		else $error("ownership underflow not aborted");
	AST_FIFO_ABORT: assert property (@(posedge aclk) disable iff (!aresetn)
		ev_fifo && !ctrl_q[5] |=> aborted_q && pend_q[7])
		else $error("under-run not handled");
	AST_HOLD_ABORT: assert property (@(posedge aclk) disable iff (!aresetn)
		aborted_q && !reactivate |=> aborted_q)
		else $error("abort released without reactivation");
	AST_ONES: assert property (@(posedge aclk) disable iff (!aresetn)
		aborted_q && tx_bit_tick |=> tx_line_bit)
		else $error("abort pattern broken");

	COV_FILTER: cover property (@(posedge aclk) disable iff (!aresetn)
		ev_filter);
	COV_MON_DOWN: cover property (@(posedge aclk) disable iff (!aresetn)
		ev_mon_down);
	COV_REACT: cover property (@(posedge aclk) disable iff (!aresetn)
		aborted_q ##1 reactivate ##1 !aborted_q);

endmodule

// ### sim/hcer_host_model.sv
// Host-side model: consumes interrupt queue descriptors, prompt or slow
`timescale 1ns/10ps
module hcer_host_model (
	input  wire logic                 aclk,
	input  wire logic                 aresetn,
	input  wire logic                 slow,
	input  wire logic                 evt_valid,
	output logic                      evt_ready,
	input  wire hcer_pkg::hcer_desc_t evt_desc,
	output logic [31:0]               ev_cnt,
	output hcer_pkg::hcer_desc_t      last_desc
);
	logic [1:0] pace_q;

	// Slow mode takes one entry in four cycles so entries sit pending
	assign evt_ready = !slow || pace_q == 2'h3;

	always_ff @(posedge aclk) begin
		if (!aresetn)
			pace_q <= 2'h0;
		else
			pace_q <= pace_q + 2'h1;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ev_cnt    <= 32'h0;
			last_desc <= '0;
		end else if (evt_valid && evt_ready) begin
			ev_cnt    <= ev_cnt + 32'h1;
			last_desc <= evt_desc;
		end
	end
endmodule

// ### sim/tb_hdlc_channel_event_reporter.sv
// Testbench: AXI4-Lite tasks, line stimulus and event checks
`timescale 1ns/10ps
module tb_hdlc_channel_event_reporter;
	logic        aclk, aresetn, in_frame_pin, slow, drop;
	logic [7:0]  s_axi_awaddr, s_axi_araddr, rx_oct, b;
	logic [31:0] s_axi_wdata, s_axi_rdata, rd, ev_cnt, ev_base;
	logic [3:0]  s_axi_wstrb;
	logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic        s_axi_rvalid, s_axi_rready, rx_oct_valid, rx_in_msg;
	logic        rx_msg_end, rx_msg_drop, tx_bit_tick, tx_data_bit;
	logic        tx_fifo_empty, tx_buf_owned, tx_next_req, tx_cur_eom;
	logic        tx_next_owned, tx_line_bit, tx_aborted, tx_poll_en;
	logic        tx_status_wr_en, evt_valid, evt_ready, irq;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	hcer_pkg::hcer_rx_err_t rx_msg_err;
	hcer_pkg::hcer_desc_t   evt_desc, last_desc;
	int          err_total, cmp_count, cyc;
	localparam logic [7:0] RA [4] = '{hcer_pkg::REG_CTRL, hcer_pkg::REG_CMD,
		hcer_pkg::REG_STATUS, hcer_pkg::REG_IMASK};
	localparam logic [31:0] SIG = 32'h1 << hcer_pkg::CTRL_SIG_MODE;

	hcer_top DUT (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
		.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .in_frame_pin,
		.rx_oct_valid, .rx_oct, .rx_in_msg, .rx_msg_end, .rx_msg_err,
		.rx_msg_drop, .tx_bit_tick, .tx_data_bit, .tx_fifo_empty,
		.tx_buf_owned, .tx_next_req, .tx_cur_eom, .tx_next_owned,
		.tx_line_bit, .tx_aborted, .tx_poll_en, .tx_status_wr_en,
		.evt_valid, .evt_ready, .evt_desc, .irq);
	hcer_host_model u_host (.aclk, .aresetn, .slow, .evt_valid, .evt_ready,
		.evt_desc, .ev_cnt, .last_desc);

	initial begin
		aclk = 1'b0;
		forever #12.5 aclk = ~aclk;
	end

	// Hang guard: the whole sequence needs well under this many cycles
	initial begin
		cyc = 0;
		forever begin
			@(posedge aclk);
			cyc++;
			if (cyc == 30000) begin
				err_total++;
				end_of_test();
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	task automatic end_of_test();
		$display("compares %0d mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] seen, exp);
		cmp_count++;
		if (seen !== exp) begin
			err_total++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	function automatic hcer_pkg::hcer_desc_t exp_desc(input int c);
		exp_desc.is_error = c >= 6;
		exp_desc.dir      = c >= 6;
		exp_desc.code     = hcer_pkg::hcer_event_t'(c);
	endfunction

	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] er);
		@(posedge aclk);
		s_axi_awaddr  <= a;
		s_axi_wdata   <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid  <= 1'b1;
		s_axi_bready  <= 1'b1;
		forever begin
			@(posedge aclk);
			if (s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid)
				break;
		end
		s_axi_bready <= 1'b0;
		chk("bresp", 32'(s_axi_bresp), 32'(er));
	endtask

	task automatic axi_rd(input logic [7:0] a, input logic [1:0] er);
		@(posedge aclk);
		s_axi_araddr  <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready  <= 1'b1;
		forever begin
			@(posedge aclk);
			if (s_axi_arready)
				s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid)
				break;
		end
		rd = s_axi_rdata;
		s_axi_rready <= 1'b0;
		chk("rresp", 32'(s_axi_rresp), 32'(er));
	endtask

	// Counts every descriptor taken, so a stray event also shows up
	task automatic expect_ev(input int c, input bit none);
		for (int n = 0; n < 60; n++) begin
			@(posedge aclk);
			if (!none && ev_cnt != ev_base)
				break;
		end
		chk("event count", ev_cnt, ev_base + 32'(!none));
		if (!none)
			chk("descriptor", 32'(last_desc), 32'(exp_desc(c)));
		ev_base = ev_cnt;
	endtask

	task automatic oct(input logic [7:0] o, input logic m);
		@(posedge aclk);
		rx_oct       <= o;
		rx_in_msg    <= m;
		rx_oct_valid <= 1'b1;
		@(posedge aclk);
		rx_oct_valid <= 1'b0;
	endtask

	task automatic msg(input int len, input logic [7:0] v, input logic [3:0] e);
		for (int i = 0; i < len; i++)
			oct(v + 8'(i), 1'b1);
		@(posedge aclk);
		rx_msg_end <= 1'b1;
		rx_msg_err <= e;
		@(posedge aclk);
		rx_msg_end <= 1'b0;
		#1 drop = rx_msg_drop;
	endtask

	task automatic tick(input logic v);
		@(posedge aclk);
		tx_bit_tick <= 1'b1;
		tx_data_bit <= v;
		@(posedge aclk);
		tx_bit_tick <= 1'b0;
		#1;
	endtask

	task automatic req(input logic end_of_message_flag, own);
		@(posedge aclk);
		tx_next_req   <= 1'b1;
		tx_cur_eom    <= end_of_message_flag;
		tx_next_owned <= own;
		@(posedge aclk);
		tx_next_req   <= 1'b0;
	endtask

	////////////////////////////////////////////////////////////////////////
	initial begin
		{in_frame_pin, rx_oct_valid, rx_in_msg, rx_msg_end, tx_bit_tick} = '0;
		{tx_data_bit, tx_fifo_empty, tx_next_req, tx_cur_eom} = '0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
		{s_axi_arvalid, s_axi_rready, tx_next_owned} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, rx_oct} = '0;
		rx_msg_err = '0;
		s_axi_wstrb = 4'hf;
		tx_buf_owned = 1'b1;
		slow = 1'b1;
		aresetn = 1'b0;
		{err_total, cmp_count, ev_base} = '0;
		void'($urandom(13716));
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		#1 chk("line idle", 32'(tx_line_bit), 32'h1);
		foreach (RA[i]) begin
			axi_rd(RA[i], hcer_pkg::RESP_OKAY);
			chk("reset value", rd, 32'h0);
		end
		axi_rd(8'h14, hcer_pkg::RESP_SLVERR);
		chk("unmapped read", rd, 32'h0);
		axi_wr(8'h14, 32'hff, hcer_pkg::RESP_SLVERR);
		oct(hcer_pkg::IDLE_OCTET, 1'b0);
		oct(hcer_pkg::ABORT_OCTET, 1'b0);
		expect_ev(0, 1'b0);
		oct(hcer_pkg::IDLE_OCTET, 1'b0);
		expect_ev(1, 1'b0);
		oct(hcer_pkg::ABORT_OCTET, 1'b1);
		expect_ev(0, 1'b1);
		axi_wr(hcer_pkg::REG_CTRL, 32'h1, hcer_pkg::RESP_OKAY);
		oct(hcer_pkg::IDLE_OCTET, 1'b0);
		oct(hcer_pkg::ABORT_OCTET, 1'b0);
		expect_ev(0, 1'b1);
		axi_wr(hcer_pkg::REG_IMASK, 32'h1, hcer_pkg::RESP_OKAY);
		chk("irq up", 32'(irq), 32'h1);
		axi_wr(hcer_pkg::REG_STATUS, 32'h1, hcer_pkg::RESP_OKAY);
		chk("irq down", 32'(irq), 32'h0);
		axi_rd(hcer_pkg::REG_STATUS, hcer_pkg::RESP_OKAY);
		chk("status", rd, 32'h2);
		@(posedge aclk);
		in_frame_pin <= 1'b1;
		expect_ev(2, 1'b0);
		in_frame_pin <= 1'b0;
		axi_wr(hcer_pkg::REG_CTRL, 32'h2, hcer_pkg::RESP_OKAY);
		in_frame_pin <= 1'b1;
		expect_ev(2, 1'b1);
		axi_wr(hcer_pkg::REG_CTRL, 32'h0, hcer_pkg::RESP_OKAY);
		msg(2, 8'h10, 4'h1);
		expect_ev(3, 1'b1);
		axi_wr(hcer_pkg::REG_CTRL, SIG, hcer_pkg::RESP_OKAY);
		for (int i = 0; i < 4; i++) begin
			msg(2, 8'($urandom), 4'h1 << i);
			expect_ev(3, 1'b0);
		end
		repeat (255)
			msg(2, 8'($urandom), 4'h0);
		expect_ev(4, 1'b1);
		msg(2, 8'($urandom), 4'h0);
		expect_ev(4, 1'b0);
		axi_rd(hcer_pkg::REG_STATE, hcer_pkg::RESP_OKAY);
		chk("monitor", 32'(rd[19:4]), 32'h3);
		for (int n = 3; n < 7; n++) begin
			b = 8'($urandom);
			msg(n, b, 4'h0);
			msg(n, b, 4'h0);
			chk("drop", 32'(drop), 32'(n < 6));
			expect_ev(5, n > 5);
		end
		msg(3, b, 4'h0);
		msg(3, b, 4'h4);
		expect_ev(3, 1'b0);
		axi_wr(hcer_pkg::REG_CTRL, SIG | 32'h10, hcer_pkg::RESP_OKAY);
		msg(4, b, 4'h0);
		msg(4, b, 4'h0);
		chk("masked drop", 32'(drop), 32'h1);
		expect_ev(5, 1'b1);
		// Masked monitor events still move the counter
		axi_wr(hcer_pkg::REG_CTRL, SIG | 32'hc, hcer_pkg::RESP_OKAY);
		msg(2, 8'($urandom), 4'h2);
		expect_ev(3, 1'b1);
		axi_rd(hcer_pkg::REG_STATE, hcer_pkg::RESP_OKAY);
		chk("masked monitor", 32'(rd[19:4]), 32'h5);
		slow <= 1'b0;
		axi_wr(hcer_pkg::REG_CTRL, 32'h0, hcer_pkg::RESP_OKAY);
		tick(1'b0);
		chk("line data", 32'(tx_line_bit), 32'h0);
		req(1'b1, 1'b0);
		req(1'b0, 1'b1);
		expect_ev(6, 1'b1);
		req(1'b0, 1'b0);
		expect_ev(6, 1'b0);
		chk("outputs", {tx_aborted, tx_poll_en, tx_status_wr_en}, 3'h4);
		for (int i = 0; i < 20; i++) begin
			tick(1'($urandom));
			chk("abort ones", 32'(tx_line_bit), 32'h1);
		end
		req(1'b0, 1'b0);
		tx_fifo_empty <= 1'b1;
		tick(1'b0);
		expect_ev(7, 1'b1);
		tx_fifo_empty <= 1'b0;
		axi_wr(hcer_pkg::REG_CMD, 32'h1, hcer_pkg::RESP_OKAY);
		tick(1'b0);
		chk("resumed", {tx_aborted, tx_poll_en, tx_line_bit}, 3'h2);
		// Device no longer owns a buffer, so an empty FIFO is no fault
		tx_buf_owned <= 1'b0;
		tx_fifo_empty <= 1'b1;
		tick(1'b0);
		expect_ev(7, 1'b1);
		tx_buf_owned <= 1'b1;
		tick(1'b0);
		expect_ev(7, 1'b0);
		chk("outputs", {tx_aborted, tx_poll_en, tx_status_wr_en}, 3'h4);
		axi_wr(hcer_pkg::REG_CMD, 32'h1, hcer_pkg::RESP_OKAY);
		axi_wr(hcer_pkg::REG_CTRL, 32'h20, hcer_pkg::RESP_OKAY);
		tick(1'b0);
		expect_ev(7, 1'b1);
		chk("masked abort", 32'(tx_aborted), 32'h1);
		end_of_test();
	end
endmodule
